// [rtl/cmp_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module cmp_bank
  import dbg_ctl_pkg::*;
#(
  parameter int BYTES = WINDOW_BYTES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Byte access
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(BYTES)-1:0] sel_i,
  input  wire logic [7:0]               wdata_i,
  output logic      [7:0]               rdata_o
);

  initial begin
    if (BYTES < 2) $error("cmp_bank: BYTES must be at least 2");
  end

  logic [7:0] mem [BYTES];

  // Byte storage of one comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < BYTES; i++) mem[i] <= 8'h00;
    end else if (wr_en_i) begin
      mem[sel_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[sel_i];

endmodule
`default_nettype wire

// [rtl/dbg_arm_ctl.sv]
// Behaviour
// - Arm bit software set/clear, auto-cleared on end
// - Arming enters state one, flags 001
// - Trigger write one requests; reads zero
// - No tracing without source; begin-tracing ignores trigger
// - Secure mode blocks tracing and trigger tracing
// - Trigger with arm together reaches final; ends session unless tracing starts
// - After triggered tracing, breakpoint per settings
// - Action select picks background mode or interrupt
// - Final state breakpoint, after tracing or immediately
// - Bank select maps comparator into window
// - Bank select chooses state control or match
// - Full flag set after 64 stored lines
// - Full cleared by arm write, power-on only
// - Full flag in status and count bit7
// - Flags follow every sequencer transition except software disarm
// - Software disarm keeps last flags
// - Internal end returns state zero, flags 000
// - Flag encoding, final state is 100
// - Status readable always, writes ignored
// - Armed: only arm, trigger, bank writable
// - Action and enable writable only while disarmed
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dbg_arm_ctl
  import dbg_ctl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and resets
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              por_i,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System state
  input  wire logic              secure_i,
  input  wire logic              bdm_enabled_i,
  input  wire logic              bdm_active_i,
  // Sequencer steps from match logic
  input  wire logic              seq_step_i,
  input  wire logic [2:0]        seq_target_i,
  input  wire logic [2:0]        match_flags_i,
  // Trace datapath
  input  wire logic              trace_store_i,
  input  wire logic              trace_done_i,
  output logic                   trace_active_o,
  output logic                   trace_align_begin_o,
  // Breakpoint requests and session status
  output logic                   bdm_break_o,
  output logic                   swi_o,
  output logic                   armed_o,
  output logic      [2:0]        sequencer_state_flags_o
);

  initial begin
    if (ADDR_W < 8) $error("dbg_arm_ctl: ADDR_W must be at least 8");
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic       arm;
  logic       breakpoint_action_select;
  logic       final_state_breakpoint_enable;
  logic [1:0] comparator_bank_select;
  logic       trace_source_enable;
  logic       trigger_alignment;
  logic [3:0] state_ctl [3];
  logic       immediate_trigger_request_pending;
  logic       tracing;
  seq_state_t seq_state;
  logic [2:0] sequencer_state_flags;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [5:0] idx;
  logic       aligned;
  logic       acc;
  logic       wr;
  logic       hit_ctl;
  logic       hit_stat;
  logic       hit_tcr;
  logic       hit_cnt;
  logic       hit_scr;
  logic       hit_win;
  logic       mapped;

  assign idx      = paddr[7:2];
  assign aligned  = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0);
  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign hit_ctl  = aligned && (idx == IDX_CONTROL_ONE);
  assign hit_stat = aligned && (idx == IDX_STATUS);
  assign hit_tcr  = aligned && (idx == IDX_TRACE_CTL);
  assign hit_cnt  = aligned && (idx == IDX_TRACE_COUNT);
  assign hit_scr  = aligned && (idx == IDX_STATE_CTL);
  assign hit_win  = aligned && (idx >= IDX_WIN_FIRST) && (idx <= IDX_WIN_LAST);
  assign mapped   = hit_ctl || hit_stat || hit_tcr || hit_cnt || hit_scr || hit_win;

  // Zero wait states; unmapped or misaligned access flags an error
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Control register write strobes
  logic wr_ctl;
  logic wr_arm_one;
  logic wr_immediate_trigger_request;
  logic cfg_open;

  assign wr_ctl     = wr && hit_ctl;
  assign wr_arm_one = wr_ctl && pwdata[CTL_ARM_BIT];
  assign wr_immediate_trigger_request    = wr_ctl && pwdata[CTL_IMMEDIATE_TRIGGER_REQUEST_BIT];
  assign cfg_open   = !arm;

  // ****************************************************************
  // Session events
  // ****************************************************************
  logic trace_en;
  logic step_ok;
  logic go_final;
  logic trace_end;
  logic session_end;
  logic brk_fire;

  // Tracing needs the source enable and an unsecured system
  assign trace_en  = trace_source_enable && !secure_i;
  // Steps only into states one to three or final
  assign step_ok   = seq_step_i && (seq_target_i != SEQ_STATE0)
                     && (seq_target_i <= SEQ_FINAL);
  // Final reached by sequencer or by trigger; ignored once tracing
  assign go_final  = arm && !tracing && !wr_ctl
                     && (immediate_trigger_request_pending || (step_ok && seq_target_i == SEQ_FINAL));
  assign trace_end = tracing && trace_done_i;
  // Session ends after tracing, or at final without tracing
  assign session_end = trace_end || (go_final && !trace_en);
  assign brk_fire    = session_end && final_state_breakpoint_enable;

  // Breakpoint routing
  logic next_bdm_break;
  logic next_swi;

  assign next_bdm_break = brk_fire && breakpoint_action_select && bdm_enabled_i;
  assign next_swi       = brk_fire && ((breakpoint_action_select && !bdm_enabled_i)
                          || (!breakpoint_action_select && !bdm_active_i));

  // ****************************************************************
  // Control register one
  // ****************************************************************
  // Arm, bank select, action and enable bits
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      arm                           <= CONTROL_ONE_RST[CTL_ARM_BIT];
      breakpoint_action_select      <= CONTROL_ONE_RST[CTL_ACTION_BIT];
      final_state_breakpoint_enable <= CONTROL_ONE_RST[CTL_BRK_BIT];
      comparator_bank_select        <= CONTROL_ONE_RST[CTL_BANK_LSB +: 2];
    end else if (wr_ctl) begin
      arm                    <= pwdata[CTL_ARM_BIT];
      comparator_bank_select <= pwdata[CTL_BANK_LSB +: 2];
      if (cfg_open) begin
        breakpoint_action_select      <= pwdata[CTL_ACTION_BIT];
        final_state_breakpoint_enable <= pwdata[CTL_BRK_BIT];
      end
    end else if (session_end) begin
      arm <= 1'b0;
    end
  end

  // Trigger request held for one cycle, acted on while armed
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      immediate_trigger_request_pending <= 1'b0;
    end else begin
      immediate_trigger_request_pending <= wr_immediate_trigger_request && pwdata[CTL_ARM_BIT];
    end
  end

  // ****************************************************************
  // Trace control and state control registers
  // ****************************************************************
  // Source enable only when disarmed and unsecured
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      trace_source_enable <= TRACE_CTL_RST[TCR_SOURCE_BIT];
      trigger_alignment   <= TRACE_CTL_RST[TCR_ALIGN_BIT];
    end else if (wr && hit_tcr && cfg_open) begin
      if (!secure_i) trace_source_enable <= pwdata[TCR_SOURCE_BIT];
      trigger_alignment <= pwdata[TCR_ALIGN_BIT];
    end
  end

  // State control set chosen by bank select; match flags read-only
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      for (int i = 0; i < 3; i++) state_ctl[i] <= STATE_CTL_RST;
    end else if (wr && hit_scr && cfg_open && comparator_bank_select != BANK_NONE) begin
      state_ctl[comparator_bank_select] <= pwdata[3:0];
    end
  end

  // ****************************************************************
  // State sequencer
  // ****************************************************************
  // Sequencer state and tracing flag
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      seq_state <= SEQ_STATE0;
      tracing   <= 1'b0;
    end else if (wr_ctl) begin
      tracing <= tracing && pwdata[CTL_ARM_BIT];
      if (pwdata[CTL_ARM_BIT] && !arm) begin
        seq_state <= SEQ_STATE1;
      end else if (!pwdata[CTL_ARM_BIT]) begin
        seq_state <= SEQ_STATE0;
      end
    end else if (session_end) begin
      seq_state <= SEQ_STATE0;
      tracing   <= 1'b0;
    end else if (go_final) begin
      seq_state <= SEQ_FINAL;
      tracing   <= trace_en;
    end else if (arm && !tracing && step_ok) begin
      seq_state <= seq_state_t'(seq_target_i);
    end
  end

  // State flags mirror the sequencer, except on software disarm
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      sequencer_state_flags <= FLAGS_RST;
    end else if (wr_ctl) begin
      if (pwdata[CTL_ARM_BIT] && !arm) begin
        sequencer_state_flags <= SEQ_STATE1;
      end
    end else if (session_end) begin
      sequencer_state_flags <= SEQ_STATE0;
    end else if (go_final) begin
      sequencer_state_flags <= SEQ_FINAL;
    end else if (arm && !tracing && step_ok) begin
      sequencer_state_flags <= seq_target_i;
    end
  end

  // Breakpoint pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      bdm_break_o <= 1'b0;
      swi_o       <= 1'b0;
    end else begin
      bdm_break_o <= next_bdm_break;
      swi_o       <= next_swi;
    end
  end

  // ****************************************************************
  // Trace fill tracking
  // ****************************************************************
  logic [5:0] line_count;
  logic       trace_full_flag;

  trace_fill #(
    .LINES (TRACE_LINES)
  ) u_fill (
    .clk_i   (clk_i),
    .por_i   (por_i),
    .clear_i (wr_arm_one),
    .store_i (tracing && trace_store_i),
    .count_o (line_count),
    .full_o  (trace_full_flag)
  );

  // ****************************************************************
  // Comparator register window
  // ****************************************************************
  logic [2:0] win_sel;
  logic [7:0] bank_rd [3];
  logic [7:0] win_rd;

  assign win_sel = idx[2:0];

  // One byte bank per comparator, written only while disarmed
  for (genvar b = 0; b < 3; b++) begin : g_bank
    cmp_bank #(
      .BYTES (WINDOW_BYTES)
    ) u_bank (
      .clk_i   (clk_i),
      .rst_i   (rst_i || por_i),
      .wr_en_i (wr && hit_win && cfg_open && comparator_bank_select == 2'(b)),
      .sel_i   (win_sel),
      .wdata_i (pwdata[7:0]),
      .rdata_o (bank_rd[b])
    );
  end

  // Selected bank, zero when none
  assign win_rd = (comparator_bank_select == BANK_A) ? bank_rd[0] :
                  (comparator_bank_select == BANK_B) ? bank_rd[1] :
                  (comparator_bank_select == BANK_C) ? bank_rd[2] : 8'h00;

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rd_ctl;
  logic [7:0] rd_stat;
  logic [7:0] rd_tcr;
  logic [7:0] rd_cnt;
  logic [7:0] rd_scr;
  logic [7:0] rd_byte;

  // Trigger bit reads zero
  assign rd_ctl  = {arm, 1'b0, 1'b0, breakpoint_action_select,
                    final_state_breakpoint_enable, 1'b0, comparator_bank_select};
  assign rd_stat = {trace_full_flag, 4'h0, sequencer_state_flags};
  assign rd_tcr  = {1'b0, trace_source_enable, 5'h00, trigger_alignment};
  assign rd_cnt  = {trace_full_flag, 1'b0, line_count};
  assign rd_scr  = (comparator_bank_select == BANK_NONE) ? {5'h00, match_flags_i}
                   : {4'h0, state_ctl[comparator_bank_select]};

  // Read multiplexer
  assign rd_byte = hit_ctl  ? rd_ctl  :
                   hit_stat ? rd_stat :
                   hit_tcr  ? rd_tcr  :
                   hit_cnt  ? rd_cnt  :
                   hit_scr  ? rd_scr  :
                   hit_win  ? win_rd  : 8'h00;

  // Registered read data, low byte only
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign armed_o                 = arm;
  assign trace_active_o          = tracing;
  assign trace_align_begin_o     = trigger_alignment;
  assign sequencer_state_flags_o = sequencer_state_flags;

endmodule
`default_nettype wire

// [rtl/dbg_ctl_pkg.sv]
package dbg_ctl_pkg;

  // ****************************************************************
  // Register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [5:0] IDX_CONTROL_ONE = 6'h20;
  localparam logic [5:0] IDX_STATUS      = 6'h21;
  localparam logic [5:0] IDX_TRACE_CTL   = 6'h22;
  localparam logic [5:0] IDX_TRACE_COUNT = 6'h26;
  localparam logic [5:0] IDX_STATE_CTL   = 6'h27;
  localparam logic [5:0] IDX_WIN_FIRST   = 6'h28;
  localparam logic [5:0] IDX_WIN_LAST    = 6'h2f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_ARM_BIT    = 7;
  localparam int CTL_IMMEDIATE_TRIGGER_REQUEST_BIT   = 6;
  localparam int CTL_ACTION_BIT = 4;
  localparam int CTL_BRK_BIT    = 3;
  localparam int CTL_BANK_LSB   = 0;
  localparam int STAT_FULL_BIT  = 7;
  localparam int TCR_SOURCE_BIT = 6;
  localparam int TCR_ALIGN_BIT  = 0;

  // ****************************************************************
  // Reset values and sizes
  // ****************************************************************
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] TRACE_CTL_RST   = 8'h00;
  localparam logic [3:0] STATE_CTL_RST   = 4'h0;
  localparam logic [2:0] FLAGS_RST       = 3'h0;
  localparam int         TRACE_LINES     = 64;
  localparam int         WINDOW_BYTES    = 8;

  // Comparator bank select codes
  localparam logic [1:0] BANK_A    = 2'h0;
  localparam logic [1:0] BANK_B    = 2'h1;
  localparam logic [1:0] BANK_C    = 2'h2;
  localparam logic [1:0] BANK_NONE = 2'h3;

  // Sequencer states, codes equal to the state flags
  typedef enum logic [2:0] {
    SEQ_STATE0 = 3'b000,
    SEQ_STATE1 = 3'b001,
    SEQ_STATE2 = 3'b010,
    SEQ_STATE3 = 3'b011,
    SEQ_FINAL  = 3'b100
  } seq_state_t;

endpackage

// [rtl/trace_fill.sv]
`timescale 1ns/1ps
`default_nettype none
module trace_fill
  import dbg_ctl_pkg::*;
#(
  parameter int LINES = TRACE_LINES
) (
  // Clock and power-on reset
  input  wire logic                     clk_i,
  input  wire logic                     por_i,
  // Control
  input  wire logic                     clear_i,
  input  wire logic                     store_i,
  // Status
  output logic      [$clog2(LINES)-1:0] count_o,
  output logic                          full_o
);

  initial begin
    if (LINES < 2 || (LINES & (LINES - 1)) != 0) $error("trace_fill: LINES must be a power of two");
  end

  localparam int CW = $clog2(LINES);
  localparam logic [CW-1:0] LAST = CW'(LINES - 1);

  // Line count wraps; full sticks once the last line is written
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      count_o <= '0;
      full_o  <= 1'b0;
    end else begin
      if (clear_i) begin
        count_o <= '0;
      end else if (store_i) begin
        count_o <= count_o + CW'(1);
      end
      // Last line stored in the cycle of an arm write still sets full
      if (store_i && count_o == LAST) begin
        full_o <= 1'b1;
      end else if (clear_i) begin
        full_o <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/dbg_arm_ctl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module dbg_arm_ctl_sva
  import dbg_ctl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and resets
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              por_i,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // System and session
  input wire logic              secure_i,
  input wire logic              bdm_enabled_i,
  input wire logic              trace_active_o,
  input wire logic              bdm_break_o,
  input wire logic              swi_o,
  input wire logic              armed_o,
  input wire logic [2:0]        sequencer_state_flags_o
);
  // ****************************************************************
  // Access decode
  // ****************************************************************
  wire logic acc   = psel && penable;
  wire logic c1_at = paddr == {IDX_CONTROL_ONE, 2'b00};
  wire logic sr_at = paddr == {IDX_STATUS, 2'b00};
  wire logic c1_wr = acc && pwrite && c1_at;
  wire logic c1_rd = acc && !pwrite && c1_at;
  wire logic c1_off = c1_wr && !pwdata[7];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || por_i);

  a_arm_state_one:
    assert property (c1_wr && pwdata[7] && !pwdata[6] && !armed_o |=> armed_o && sequencer_state_flags_o == 3'b001)
    else $error("arming did not enter state one");
  a_no_reserved:
    assert property (sequencer_state_flags_o <= 3'b100) else $error("reserved state code seen");
  a_internal_end_zero:
    assert property ($fell(armed_o) && !$past(c1_wr) |-> sequencer_state_flags_o == 3'b000)
    else $error("internal end left flags set");
  a_disarm_keeps:
    assert property (c1_off && armed_o |=> $stable(sequencer_state_flags_o)) else $error("disarm changed flags");
  a_bg_needs_enable:
    assert property (bdm_break_o |-> $past(bdm_enabled_i) && !swi_o) else $error("background break without enable");
  a_brk_after_end:
    assert property (bdm_break_o || swi_o |-> !armed_o && $past(armed_o))
    else $error("breakpoint not one cycle after end");
  a_immediate_trigger_request_reads_zero:
    assert property (c1_rd |-> prdata[6] == 1'b0 && prdata[7] == $past(armed_o)) else $error("control read wrong");
  a_status_flags:
    assert property (acc && !pwrite && sr_at |-> prdata[2:0] == $past(sequencer_state_flags_o) && !pslverr)
    else $error("status read wrong");
  a_secure_no_trace:
    assert property (secure_i && $past(secure_i) |-> !$rose(trace_active_o)) else $error("tracing while secure");
endmodule

bind dbg_arm_ctl dbg_arm_ctl_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .secure_i(secure_i),
  .bdm_enabled_i(bdm_enabled_i), .trace_active_o(trace_active_o), .bdm_break_o(bdm_break_o),
  .swi_o(swi_o), .armed_o(armed_o), .sequencer_state_flags_o(sequencer_state_flags_o));
`default_nettype wire

// [testbench/sys_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sys_model (
  // Clock
  input  wire logic clk_i,
  // From debug block
  input  wire logic trace_active_i,
  input  wire logic bdm_break_i,
  input  wire logic swi_i,
  // To debug block
  output logic      trace_store_o,
  output logic      trace_done_o
);
  // ****************************************************************
  // Core and background side
  // ****************************************************************
  int n_bg = 0;
  int n_soft = 0;

  initial begin
    trace_store_o = 1'b0;
    trace_done_o = 1'b0;
  end

  // Count breakpoint requests taken by the core
  always @(posedge clk_i) begin
    if (bdm_break_i) n_bg <= n_bg + 1;
    if (swi_i) n_soft <= n_soft + 1;
  end

  // Stores lines only while a session traces, one every other cycle
  task automatic store(input int n);
    repeat (n) begin
      @(posedge clk_i);
      trace_store_o <= trace_active_i;
      @(posedge clk_i);
      trace_store_o <= 1'b0;
    end
  endtask

  // Datapath reports the end of tracing
  task automatic finish();
    @(posedge clk_i);
    trace_done_o <= 1'b1;
    @(posedge clk_i);
    trace_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import dbg_ctl_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [7:0] C1 = {IDX_CONTROL_ONE, 2'b00};
  localparam logic [7:0] SR = {IDX_STATUS, 2'b00};
  localparam logic [7:0] TC = {IDX_TRACE_CTL, 2'b00};
  localparam logic [7:0] CN = {IDX_TRACE_COUNT, 2'b00};
  localparam logic [7:0] SC = {IDX_STATE_CTL, 2'b00};
  localparam logic [7:0] WN = {IDX_WIN_FIRST, 2'b00};
  localparam logic [7:0] WL = {IDX_WIN_LAST, 2'b00};
  logic        clk_i, rst_i, por_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        secure_i, bdm_enabled_i, bdm_active_i, seq_step_i, trace_store_i, trace_done_i;
  logic [2:0]  seq_target_i, match_flags_i, sequencer_state_flags_o;
  logic        trace_active_o, trace_align_begin_o, bdm_break_o, swi_o, armed_o;
  int          n_fail = 0;
  int          samples_checked = 0;

  dbg_arm_ctl #(.ADDR_W(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .secure_i(secure_i), .bdm_enabled_i(bdm_enabled_i), .bdm_active_i(bdm_active_i),
    .seq_step_i(seq_step_i), .seq_target_i(seq_target_i), .match_flags_i(match_flags_i),
    .trace_store_i(trace_store_i), .trace_done_i(trace_done_i), .trace_active_o(trace_active_o),
    .trace_align_begin_o(trace_align_begin_o), .bdm_break_o(bdm_break_o), .swi_o(swi_o),
    .armed_o(armed_o), .sequencer_state_flags_o(sequencer_state_flags_o));

  sys_model sm (
    .clk_i(clk_i), .trace_active_i(trace_active_o), .bdm_break_i(bdm_break_o), .swi_i(swi_o),
    .trace_store_o(trace_store_i), .trace_done_o(trace_done_i));

  // Clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 8'h00);
    chk(rdv & m, e);
  endtask

  task automatic step(input logic [2:0] t);
    seq_step_i <= 1'b1;
    seq_target_i <= t;
    @(posedge clk_i);
    seq_step_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int ns;
    {rst_i, por_i} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {secure_i, bdm_enabled_i, bdm_active_i, seq_step_i, seq_target_i} = '0;
    match_flags_i = 3'b101;
    wt(12);
    {rst_i, por_i} <= 2'b00;
    rd(C1, 32'h0);
    rd(CN, 32'h0);
    wr(SR, 8'hff);
    rd(SR, 32'h0);
    rd(8'h00, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
    wr(C1, 8'h80);
    rd(SR, 32'h1);
    wr(C1, 8'h98);
    rd(C1, 32'h80);
    step(3'd2);
    rd(SR, 32'h2);
    step(3'd6);
    rd(SR, 32'h2);
    wr(C1, 8'h18);
    rd(C1, 32'h0);
    rd(SR, 32'h2);
    wr(C1, 8'h5b);
    rd(C1, 32'h1b);
    $display("test arm done");
    for (int b = 0; b < 3; b++) begin
      wr(C1, b[7:0]);
      wr(SC, 8'h05 + b[7:0]);
      wr(WN, 8'h10 + b[7:0]);
      wr(WL, 8'h20 + b[7:0]);
    end
    wr(C1, 8'h03);
    wr(WN, 8'hff);
    rd(SC, 32'h5);
    rd(WN, 32'h0);
    wr(C1, 8'h80);
    wr(WN, 8'hee);
    wr(C1, 8'h00);
    for (int b = 0; b < 3; b++) begin
      wr(C1, b[7:0]);
      rd(SC, 32'h5 + b);
      rd(WN, 32'h10 + b);
      rd(WL, 32'h20 + b);
    end
    $display("test bank done");
    for (int i = 0; i < 16; i++) begin
      if (i[1:0] == 2'b01) continue;
      bdm_enabled_i <= i[1];
      bdm_active_i <= i[0];
      ns = sm.n_bg + sm.n_soft * 16;
      wr(C1, {3'b100, i[2], i[3], 3'b000});
      step(3'd4);
      wt(5);
      chk(sm.n_bg + sm.n_soft * 16 - ns, (i[3] & i[2] & i[1]) + 16 * (i[3] & (i[2] ? !i[1] : !i[0])));
      rd(C1, {27'h0, i[2], i[3], 3'b000});
      rd(SR, 32'h0);
    end
    {bdm_enabled_i, bdm_active_i} <= 2'b00;
    $display("test breakpoint done");
    ns = sm.n_soft;
    wr(TC, 8'h40);
    wr(C1, 8'h88);
    step(3'd4);
    wt(3);
    chk(trace_active_o, 1'b1);
    rd(SR, 32'h4);
    sm.store(63);
    rd(CN, 32'h3f);
    sm.store(1);
    rd(SR, 32'h84);
    rd(CN, 32'h80, 32'h80);
    chk(sm.n_soft - ns, 0);
    sm.finish();
    wt(5);
    chk(sm.n_soft - ns, 1);
    rd(SR, 32'h80);
    rst_i <= 1'b1;
    wt(2);
    rst_i <= 1'b0;
    rd(SR, 32'h80);
    wr(C1, 8'h80);
    rd(SR, 32'h1);
    wr(C1, 8'hc0);
    wt(3);
    chk(trace_active_o, 1'b0);
    rd(C1, 32'h0);
    rd(SR, 32'h0);
    $display("test trace done");
    wr(TC, 8'h40);
    secure_i <= 1'b1;
    wr(C1, 8'hc0);
    wt(3);
    chk(trace_active_o, 1'b0);
    rd(C1, 32'h0);
    secure_i <= 1'b0;
    wr(TC, 8'h41);
    chk(trace_align_begin_o, 1'b1);
    ns = sm.n_soft;
    wr(C1, 8'hc8);
    wt(3);
    chk(trace_active_o, 1'b1);
    wr(C1, 8'hc8);
    wt(3);
    chk(trace_active_o, 1'b1);
    sm.finish();
    wt(5);
    chk(sm.n_soft - ns, 1);
    chk(armed_o, 1'b0);
    $display("test trigger done");
    end_of_test();
  end
endmodule
`default_nettype wire
